// [pkg/seq_pkg.sv]
// Purpose: shared constants for the program sequencing core
// Assumes: hclk at 100 MHz stands in for the oscillator clock
// Notes: offsets are byte addresses on the AHB-Lite register slave
package seq_pkg;
	localparam int PC_W = 12;
	localparam int ROM_AW = 11;
	localparam int ROM_DEPTH = 2048;
	localparam int PAGE_WORDS = 1024;
	localparam int STACK_DEPTH = 8;
	localparam int RAM_DEPTH = 64;
	localparam logic [11:0] PC_RST = 12'h000;
	// Register offsets
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_PC = 8'h04;
	localparam logic [7:0] A_TC = 8'h08;
	localparam logic [7:0] A_CTRL = 8'h0c;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_CFG = 8'h14;
	localparam logic [7:0] A_RSEL = 8'h18;
	localparam logic [7:0] A_IND = 8'h1c;
	localparam logic [7:0] A_PRE = 8'h20;
	localparam logic [7:0] A_SP = 8'h24;
	localparam logic [7:0] A_LIT = 8'h28;
	// Command word fields
	localparam int CMD_OP_LSB = 12;
	localparam int CMD_BUSY = 16;
	// Operation codes
	localparam logic [3:0] OP_STEP = 4'h0;
	localparam logic [3:0] OP_JUMP = 4'h1;
	localparam logic [3:0] OP_CALL = 4'h2;
	localparam logic [3:0] OP_RETURN = 4'h3;
	localparam logic [3:0] OP_RETLIT = 4'h4;
	localparam logic [3:0] OP_RETINT = 4'h5;
	localparam logic [3:0] OP_ADDPC = 4'h6;
	localparam logic [3:0] OP_MOVPC = 4'h7;
	localparam logic [3:0] OP_BSET = 4'h8;
	localparam logic [3:0] OP_BCLR = 4'h9;
	// Counter control bits
	localparam int CT_INT_RISE = 7;
	localparam int CT_SRC_PIN = 5;
	localparam int CT_EDGE_FALL = 4;
	localparam int CT_PS_BYPASS = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Status and configuration bits
	localparam int ST_PAGE = 5;
	localparam int ST_INT = 0;
	localparam int CF_CYCLE = 0;
	localparam int CF_DIV4 = 1;
	localparam int CF_RSTEN = 2;
	localparam logic [7:0] CFG_RST = 8'h04;
	// Instruction cycle as last divider count, hclk periods minus one (fclk/2 or fclk/4)
	localparam logic [1:0] DIV_FAST = 2'h1;
	localparam logic [1:0] DIV_SLOW = 2'h3;
endpackage : seq_pkg

// [pkg/stack_if.sv]
// Purpose: carrier between the sequencer and its return stack
// Assumes: one push or one pop per hclk at most
// Notes: top is the most recently pushed entry
`timescale 1ns/1ps
`default_nettype none
interface stack_if;
	logic push;
	logic pop;
	logic [11:0] wdata;
	logic [11:0] top;
	logic [2:0] level;
	modport ctrl (output push, output pop, output wdata, input top, input level);
	modport stk (input push, input pop, input wdata, output top, output level);
endinterface : stack_if
`default_nettype wire

// [core/ret_stack.sv]
// Purpose: eight level circular return stack
// Assumes: push and pop never asserted together
// Notes: overflow silently overwrites the oldest entry
`timescale 1ns/1ps
`default_nettype none
module ret_stack (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Stack port
	stack_if.stk s
);
	logic [11:0] mem [seq_pkg::STACK_DEPTH];
	logic [2:0] ptr;

	// Pointer wraps on both ends, no error raised
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr <= 3'h0;
		end else if (s.push) begin
			ptr <= ptr + 3'h1;
		end else if (s.pop) begin
			ptr <= ptr - 3'h1;
		end
	end

	// Storage carries no reset, like the real stack RAM
	always_ff @(posedge hclk) begin
		if (s.push) begin
			mem[ptr] <= s.wdata;
		end
	end

	assign s.top = mem[ptr - 3'h1];
	assign s.level = ptr;

	chk_push_top: assert property (@(posedge hclk) disable iff (!hresetn)
		s.push |=> s.top == $past(s.wdata)) else $error("pushed word not on top");
	chk_stack_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.push && ptr == 3'h7) |=> ptr == 3'h0) else $error("stack did not wrap");
endmodule : ret_stack
`default_nettype wire

// [core/seq_core.sv]
// Purpose: program counter, return stack and core registers behind AHB-Lite
// Assumes: single word transfers; pins are asynchronous to hclk
// Notes: every bus access takes one wait state
// How it works
// - indirect pointer has no storage; it reaches RAM at the RAM select address.
// - time counter counts external pin edges or instruction cycles, as configured.
// - software reads and writes the time counter like any data register.
// - writing the time counter clears the prescaler count.
// - writing the prescaler select bits 3..0 clears the prescaler count.
// - every reset source clears the prescaler count.
// - program counter and stack entries are 12 bits wide.
// - counter addresses a 2K word ROM in pages of 1024 words.
// - any reset clears the whole program counter.
// - jump loads its operand into counter bits 9..0.
// - call loads bits 9..0 and pushes the next address.
// - all three return kinds reload the counter from the stack top.
// - adding the accumulator to the counter is a full carry add.
// - moving the accumulator replaces bits 7..0; bits 9..8 stay.
// - other counter writes, bit operations included, keep bits 9..8.
// - jump, call or counter write other than the add loads bit 10 from page select; the add carries into it.
// - instruction cycle is fclk/2 or fclk/4; counter writes take 1 or 2.
// - device stays reset while the enabled reset pin is low.
// - external interrupt edge is falling or rising per control bit 7.
// - page select 0 picks addresses 000-3FF, 1 picks 400-7FF.
// - returns leave page select untouched.
// - return stack holds eight levels.
`timescale 1ns/1ps
`default_nettype none
module seq_core (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins and system
	input wire logic reset_pin_n,
	input wire logic counter_pin,
	input wire logic ext_int_pin,
	input wire logic wdt_timeout,
	// Program ROM side and interrupt pulse out
	output logic [10:0] rom_addr,
	output logic ext_int_pulse
);
	typedef enum logic [1:0] {B_IDLE = 2'b01, B_ACC = 2'b10} bus_t;
	typedef enum logic [2:0] {X_IDLE = 3'b001, X_WAIT = 3'b010, X_EXTRA = 3'b100} exec_t;

	bus_t bstate;
	exec_t xstate;
	logic [7:0] addr_q;
	logic wr_q;
	logic [11:0] pc;
	logic [3:0] op_q;
	logic [9:0] opnd_q;
	logic [7:0] tc, ctrl, presc, cfg, rsel, lit;
	logic page, int_flag;
	logic [1:0] div;
	logic [2:0] meta, sync, prev;
	logic [7:0] ram [seq_pkg::RAM_DEPTH];
	logic [31:0] rd_word;
	logic accept, wr_ev, tick, fire, core_rst;
	logic pin_hit, int_hit, cnt_evt, tc_inc;
	logic [7:0] lim;
	stack_if sif ();

	function automatic logic edge_hit(input logic p, input logic c, input logic fall);
		edge_hit = fall ? (p & ~c) : (~p & c);
	endfunction : edge_hit

	function automatic logic wsel(input logic ev, input logic [7:0] a, input logic [7:0] t);
		wsel = ev && (a == t);
	endfunction : wsel

	function automatic logic pc_writer(input logic [3:0] op);
		pc_writer = (op != seq_pkg::OP_STEP);
	endfunction : pc_writer

	ret_stack u_stack (
		.hclk(hclk),
		.hresetn(hresetn),
		.s(sif.stk)
	);

	// Two flops on every pin before use; third stage keeps the edge history
	// Reset to the pins' idle levels so no false edge follows reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= 3'h5;
			sync <= 3'h5;
			prev <= 3'h5;
		end else begin
			meta <= {ext_int_pin, counter_pin, reset_pin_n};
			sync <= meta;
			prev <= sync;
		end
	end

	// Pin reset holds the core as long as it is low
	assign core_rst = (cfg[seq_pkg::CF_RSTEN] & ~sync[0]) | wdt_timeout;

	// Instruction cycle tick from hclk, divide by 2 or 4
	assign tick = (div == (cfg[seq_pkg::CF_DIV4] ? seq_pkg::DIV_SLOW : seq_pkg::DIV_FAST));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 2'h0;
		end else begin
			div <= tick ? 2'h0 : div + 2'h1;
		end
	end

	// Bus slave: address phase captured, answer one cycle later
	assign accept = hsel & htrans[1] & hready;
	assign wr_ev = (bstate == B_ACC) & wr_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bstate <= B_IDLE;
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			unique case (bstate)
				B_IDLE: begin
					if (accept) begin
						bstate <= B_ACC;
						addr_q <= haddr[7:0];
						wr_q <= hwrite;
						hreadyout <= 1'b0;
					end
				end
				B_ACC: begin
					bstate <= B_IDLE;
					hreadyout <= 1'b1;
					if (!wr_q) begin
						hrdata <= rd_word;
					end
				end
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (addr_q)
			seq_pkg::A_CMD: rd_word = {15'h0000, xstate != X_IDLE, op_q, 2'h0, opnd_q};
			seq_pkg::A_PC: rd_word = {20'h00000, pc};
			seq_pkg::A_TC: rd_word = {24'h000000, tc};
			seq_pkg::A_CTRL: rd_word = {24'h000000, ctrl};
			seq_pkg::A_STAT: rd_word = {26'h0000000, page, 4'h0, int_flag};
			seq_pkg::A_CFG: rd_word = {24'h000000, cfg};
			seq_pkg::A_RSEL: rd_word = {24'h000000, rsel};
			seq_pkg::A_IND: rd_word = {24'h000000, ram[rsel[5:0]]};
			seq_pkg::A_PRE: rd_word = {24'h000000, presc};
			seq_pkg::A_SP: rd_word = {29'h00000000, sif.level};
			seq_pkg::A_LIT: rd_word = {24'h000000, lit};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Software registers; the RAM select top bit always reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= seq_pkg::CTRL_RST;
			cfg <= seq_pkg::CFG_RST;
			rsel <= 8'h00;
			page <= 1'b0;
		end else begin
			if (wsel(wr_ev, addr_q, seq_pkg::A_CTRL)) begin
				ctrl <= hwdata[7:0];
			end
			if (wsel(wr_ev, addr_q, seq_pkg::A_CFG)) begin
				cfg <= hwdata[7:0];
			end
			if (wsel(wr_ev, addr_q, seq_pkg::A_RSEL)) begin
				rsel <= {1'b0, hwdata[6:0]};
			end
			if (wsel(wr_ev, addr_q, seq_pkg::A_STAT)) begin
				page <= hwdata[seq_pkg::ST_PAGE];
			end
		end
	end

	// Indirect pointer owns no flop: writes land in the selected RAM word
	always_ff @(posedge hclk) begin
		if (wsel(wr_ev, addr_q, seq_pkg::A_IND)) begin
			ram[rsel[5:0]] <= hwdata[7:0];
		end
	end

	// External interrupt edge; a new edge beats a same-cycle clear
	assign int_hit = edge_hit(prev[2], sync[2], ~ctrl[seq_pkg::CT_INT_RISE]);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_flag <= 1'b0;
			ext_int_pulse <= 1'b0;
		end else begin
			ext_int_pulse <= int_hit;
			if (int_hit) begin
				int_flag <= 1'b1;
			end else if (wsel(wr_ev, addr_q, seq_pkg::A_STAT) && hwdata[seq_pkg::ST_INT]) begin
				int_flag <= 1'b0;
			end
		end
	end

	// Counter source and prescaler terminal count (2 to 256)
	assign pin_hit = edge_hit(prev[1], sync[1], ctrl[seq_pkg::CT_EDGE_FALL]);
	assign cnt_evt = ctrl[seq_pkg::CT_SRC_PIN] ? pin_hit : tick;
	assign lim = 8'hff >> (3'h7 - ctrl[2:0]);
	assign tc_inc = cnt_evt & (ctrl[seq_pkg::CT_PS_BYPASS] | (presc == lim));

	// Prescaler count; any control write rewrites the select bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc <= 8'h00;
		end else if (core_rst) begin
			presc <= 8'h00;
		end else if (wsel(wr_ev, addr_q, seq_pkg::A_TC)) begin
			presc <= 8'h00;
		end else if (wsel(wr_ev, addr_q, seq_pkg::A_CTRL)) begin
			presc <= 8'h00;
		end else if (cnt_evt && !ctrl[seq_pkg::CT_PS_BYPASS]) begin
			presc <= (presc == lim) ? 8'h00 : presc + 8'h01;
		end
	end

	// Time counter; a software write wins over a count in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tc <= 8'h00;
		end else if (wsel(wr_ev, addr_q, seq_pkg::A_TC)) begin
			tc <= hwdata[7:0];
		end else if (tc_inc) begin
			tc <= tc + 8'h01;
		end
	end

	// Command sequencer: commands written while busy are dropped
	assign fire = (xstate == X_WAIT) & tick & ~core_rst;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xstate <= X_IDLE;
			op_q <= seq_pkg::OP_STEP;
			opnd_q <= 10'h000;
		end else if (core_rst) begin
			xstate <= X_IDLE;
		end else begin
			unique case (xstate)
				X_IDLE: begin
					if (wsel(wr_ev, addr_q, seq_pkg::A_CMD)) begin
						op_q <= hwdata[15:12];
						opnd_q <= hwdata[9:0];
						xstate <= X_WAIT;
					end
				end
				X_WAIT: begin
					if (tick) begin
						xstate <= (pc_writer(op_q) && cfg[seq_pkg::CF_CYCLE]) ? X_EXTRA : X_IDLE;
					end
				end
				X_EXTRA: begin
					if (tick) begin
						xstate <= X_IDLE;
					end
				end
			endcase
		end
	end

	// Stack traffic for call and the three returns
	assign sif.push = fire & (op_q == seq_pkg::OP_CALL);
	assign sif.pop = fire & ((op_q == seq_pkg::OP_RETURN) | (op_q == seq_pkg::OP_RETLIT)
		| (op_q == seq_pkg::OP_RETINT));
	assign sif.wdata = pc + 12'h001;

	// Program counter; returns never touch page so callers' page comes back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= seq_pkg::PC_RST;
			lit <= 8'h00;
		end else if (core_rst) begin
			pc <= seq_pkg::PC_RST;
		end else if (fire) begin
			case (op_q)
				seq_pkg::OP_JUMP, seq_pkg::OP_CALL: pc <= {pc[11], page, opnd_q};
				seq_pkg::OP_RETURN, seq_pkg::OP_RETINT: pc <= sif.top;
				seq_pkg::OP_RETLIT: begin
					pc <= sif.top;
					lit <= opnd_q[7:0];
				end
				seq_pkg::OP_ADDPC: pc <= pc + {4'h0, opnd_q[7:0]};
				seq_pkg::OP_MOVPC: pc <= {pc[11], page, pc[9:8], opnd_q[7:0]};
				seq_pkg::OP_BSET: pc <= {pc[11], page, pc[9:8], pc[7:0] | (8'h01 << opnd_q[2:0])};
				seq_pkg::OP_BCLR: pc <= {pc[11], page, pc[9:8], pc[7:0] & ~(8'h01 << opnd_q[2:0])};
				default: pc <= pc + 12'h001;
			endcase
		end
	end

	// ROM address is the low 11 counter bits; bit 10 is the page
	assign rom_addr = pc[seq_pkg::ROM_AW-1:0];

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_pc_reset: assert property (core_rst |=> pc == seq_pkg::PC_RST) else $error("pc not cleared");
	chk_presc_twrite: assert property (wsel(wr_ev, addr_q, seq_pkg::A_TC) |=> presc == 8'h00)
		else $error("prescaler kept after counter write");
	chk_presc_ctrl: assert property (wsel(wr_ev, addr_q, seq_pkg::A_CTRL) |=> presc == 8'h00)
		else $error("prescaler kept after control write");
	chk_presc_reset: assert property (core_rst |=> presc == 8'h00) else $error("prescaler kept on reset");
	chk_jump_load: assert property ((fire && op_q == seq_pkg::OP_JUMP) |=>
		pc[9:0] == $past(opnd_q) && pc[10] == $past(page)) else $error("jump load wrong");
	chk_call_push: assert property ((fire && op_q == seq_pkg::OP_CALL) |=>
		sif.top == $past(pc) + 12'h001 && pc[9:0] == $past(opnd_q)) else $error("call push wrong");
	chk_return_top: assert property (sif.pop |=> pc == $past(sif.top) && page == $past(page))
		else $error("return reload wrong");
	chk_add_carry: assert property ((fire && op_q == seq_pkg::OP_ADDPC) |=>
		pc == $past(pc) + {4'h0, $past(opnd_q[7:0])}) else $error("relative add wrong");
	chk_move_keep: assert property ((fire && op_q == seq_pkg::OP_MOVPC) |=>
		pc[9:8] == $past(pc[9:8]) && pc[7:0] == $past(opnd_q[7:0]) && pc[10] == $past(page))
		else $error("move changed high bits");
	chk_count_step: assert property ((tc_inc && !wr_ev) |=> tc == $past(tc) + 8'h01)
		else $error("time counter missed a count");
	chk_two_cycle: assert property ((fire && pc_writer(op_q) && cfg[seq_pkg::CF_CYCLE]) |=>
		xstate == X_EXTRA) else $error("second cycle missing");

	cov_call_return: cover property ((fire && op_q == seq_pkg::OP_CALL) ##[1:40] sif.pop);
	cov_tc_write: cover property (wsel(wr_ev, addr_q, seq_pkg::A_TC));
	cov_int_edge: cover property (int_hit);
endmodule : seq_core
`default_nettype wire

// [testbench/rom_model.sv]
// Purpose: program ROM facing the sequencing core fetch address
// Assumes: 2K words of 13 bits, addressed straight from the counter
// Notes: contents are a traceable pattern, not a real program
`timescale 1ns/1ps
`default_nettype none
module rom_model (
	// Fetch side
	input wire logic [10:0] rom_addr,
	output logic [12:0] rom_word
);
	logic [12:0] mem [0:2047];
	// Address-derived pattern so a wrong fetch shows in the word
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 13'(i) ^ 13'h1555;
		end
	end
	// Asynchronous read, as a fetch path would see it
	assign rom_word = mem[rom_addr];
endmodule : rom_model
`default_nettype wire

// [testbench/program_counter_stack_and_core_regs_test.sv]
// Purpose: self-checking bench for the sequencing core over AHB-Lite
// Assumes: one wait state per transfer, commands polled through busy
// Notes: stack contents after a core reset are not relied upon
`timescale 1ns/1ps
`default_nettype none
module program_counter_stack_and_core_regs_test;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic reset_pin_n, counter_pin, ext_int_pin, wdt_timeout, ext_int_pulse, page;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans;
	logic [2:0] hsize, sp;
	logic [10:0] rom_addr;
	logic [12:0] rom_word;
	logic [11:0] pc_m;
	logic [11:0] stk [0:7];
	logic [7:0] vld;
	logic [3:0] o;
	logic [9:0] k;
	integer seed = 81;
	integer err_total = 0;
	integer n_checks = 0;
	integer pulses = 0;

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	seq_core i_seq_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
		.counter_pin(counter_pin), .ext_int_pin(ext_int_pin), .wdt_timeout(wdt_timeout),
		.rom_addr(rom_addr), .ext_int_pulse(ext_int_pulse));
	rom_model i_rom_model (.rom_addr(rom_addr), .rom_word(rom_word));

	// Interrupt pulses counted where they leave the core
	always @(posedge hclk) if (ext_int_pulse === 1'b1) pulses <= pulses + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; waits on ready, no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask : rdc

	task automatic pin_edges(input int n);
		repeat (n) begin
			@(posedge hclk) counter_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			counter_pin <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask : pin_edges

	// Next counter for every command that does not return
	function automatic logic [11:0] pc_exp(input logic [3:0] c, input logic [9:0] n,
		input logic [11:0] p, input logic pg);
		pc_exp = p + 12'h001;
		case (c)
			seq_pkg::OP_JUMP, seq_pkg::OP_CALL: pc_exp = {p[11], pg, n};
			seq_pkg::OP_ADDPC: pc_exp = p + {4'h0, n[7:0]};
			seq_pkg::OP_MOVPC: pc_exp = {p[11], pg, p[9:8], n[7:0]};
			seq_pkg::OP_BSET, seq_pkg::OP_BCLR: begin
				pc_exp = {p[11], pg, p[9:0]};
				pc_exp[n[2:0]] = (c == seq_pkg::OP_BSET);
			end
			default: ;
		endcase
	endfunction : pc_exp

	// Issue a command, wait for busy to drop, then check against the model
	task automatic op(input logic [3:0] c, input logic [9:0] n);
		logic [11:0] nx;
		wr(seq_pkg::A_CMD, {16'h0, c, 2'h0, n});
		do bus(1'b0, seq_pkg::A_CMD, 32'h0, v); while (v[16] !== 1'b0);
		nx = pc_exp(c, n, pc_m, page);
		case (c)
			seq_pkg::OP_CALL: begin
				stk[sp] = pc_m + 12'h001;
				vld[sp] = 1'b1;
				sp = sp + 3'h1;
			end
			seq_pkg::OP_RETURN, seq_pkg::OP_RETLIT, seq_pkg::OP_RETINT: begin
				sp = sp - 3'h1;
				nx = stk[sp];
			end
			default: ;
		endcase
		pc_m = nx;
		rdc(seq_pkg::A_PC, {20'h0, pc_m});
		chk({19'h0, rom_word}, {19'h0, {2'h0, pc_m[10:0]} ^ 13'h1555});
		rdc(seq_pkg::A_SP, {29'h0, sp});
		if (c == seq_pkg::OP_RETLIT) rdc(seq_pkg::A_LIT, {24'h0, n[7:0]});
	endtask : op

	task automatic results;
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		#500000;
		err_total++;
		results();
	end

	initial begin
		{hresetn, hsel, hwrite, counter_pin, wdt_timeout} = 5'h0;
		{reset_pin_n, ext_int_pin, page} = 3'h6;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		{pc_m, sp, vld} = 23'h0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(seq_pkg::A_PC, 32'h0);
		rdc(seq_pkg::A_CFG, 32'h4);
		// Prescaler fed by pin edges, large ratio so the counter stays put
		wr(seq_pkg::A_CTRL, 32'h27);
		pin_edges(5);
		rdc(seq_pkg::A_PRE, 32'h5);
		wr(seq_pkg::A_TC, 32'h33);
		rdc(seq_pkg::A_PRE, 32'h0);
		rdc(seq_pkg::A_TC, 32'h33);
		pin_edges(3);
		wr(seq_pkg::A_CTRL, 32'h27);
		rdc(seq_pkg::A_PRE, 32'h0);
		// Ratio 1:4 through the prescaler: nine edges give two counts, one left over
		wr(seq_pkg::A_CTRL, 32'h21);
		wr(seq_pkg::A_TC, 32'h0);
		pin_edges(9);
		rdc(seq_pkg::A_TC, 32'h2);
		rdc(seq_pkg::A_PRE, 32'h1);
		// Bypass on falling edge: the rising edge must not count
		wr(seq_pkg::A_CTRL, 32'h38);
		wr(seq_pkg::A_TC, 32'hff);
		@(posedge hclk) counter_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		rdc(seq_pkg::A_TC, 32'hff);
		counter_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		rdc(seq_pkg::A_TC, 32'h0);
		wr(seq_pkg::A_CTRL, 32'h08);
		wr(seq_pkg::A_TC, 32'h0);
		bus(1'b0, seq_pkg::A_TC, 32'h0, v);
		// Three edges between write and read data: one or two cycle ticks
		chk({31'h0, v[7:0] inside {8'h01, 8'h02}}, 32'h1);
		// Indirect pointer reaches RAM at the select address
		wr(seq_pkg::A_RSEL, 32'h05);
		wr(seq_pkg::A_IND, 32'ha5);
		wr(seq_pkg::A_RSEL, 32'h06);
		wr(seq_pkg::A_IND, 32'h3c);
		wr(seq_pkg::A_RSEL, 32'h85);
		rdc(seq_pkg::A_RSEL, 32'h05);
		rdc(seq_pkg::A_IND, 32'ha5);
		wr(seq_pkg::A_RSEL, 32'h06);
		rdc(seq_pkg::A_IND, 32'h3c);
		wr(8'h30, 32'hff);
		rdc(8'h30, 32'h0);
		// Interrupt edge select, falling then rising
		wr(seq_pkg::A_CTRL, 32'h20);
		@(posedge hclk) ext_int_pin <= 1'b0;
		repeat (8) @(posedge hclk);
		rdc(seq_pkg::A_STAT, 32'h01);
		wr(seq_pkg::A_STAT, 32'h01);
		rdc(seq_pkg::A_STAT, 32'h00);
		wr(seq_pkg::A_CTRL, 32'ha0);
		@(posedge hclk) ext_int_pin <= 1'b1;
		repeat (8) @(posedge hclk);
		rdc(seq_pkg::A_STAT, 32'h01);
		chk(pulses, 32'h2);
		wr(seq_pkg::A_STAT, 32'h01);
		// Counter corner cases: carry into the page bit, partial loads
		op(seq_pkg::OP_JUMP, 10'h3f0);
		op(seq_pkg::OP_ADDPC, 10'h020);
		op(seq_pkg::OP_JUMP, 10'h2f0);
		op(seq_pkg::OP_MOVPC, 10'h012);
		op(seq_pkg::OP_BSET, 10'h007);
		op(seq_pkg::OP_BCLR, 10'h001);
		page = 1'b1;
		wr(seq_pkg::A_STAT, 32'h20);
		op(seq_pkg::OP_JUMP, 10'h155);
		op(seq_pkg::OP_CALL, 10'h0aa);
		page = 1'b0;
		wr(seq_pkg::A_STAT, 32'h00);
		op(seq_pkg::OP_RETINT, 10'h0);
		rdc(seq_pkg::A_STAT, 32'h00);
		op(seq_pkg::OP_CALL, 10'h001);
		op(seq_pkg::OP_RETLIT, 10'h05a);
		// Random commands, page flips and cycle options
		repeat (60) begin
			o = 4'($random(seed));
			k = 10'($random(seed));
			if (o inside {4'h3, 4'h4, 4'h5} && !vld[sp - 3'h1]) o = seq_pkg::OP_CALL;
			if (k[9:8] == 2'h3) begin
				page = k[0];
				wr(seq_pkg::A_STAT, {26'h0, page, 5'h0});
				wr(seq_pkg::A_CFG, {29'h0, 1'b1, k[2:1]});
			end
			op(o, k);
		end
		// Nine calls overflow the eight levels
		for (int i = 0; i < 9; i++) op(seq_pkg::OP_CALL, 10'(i));
		repeat (8) op(seq_pkg::OP_RETURN, 10'h0);
		// Reset pin then watchdog time-out
		op(seq_pkg::OP_JUMP, 10'h0ff);
		wr(seq_pkg::A_CTRL, 32'h27);
		pin_edges(3);
		@(posedge hclk) reset_pin_n <= 1'b0;
		repeat (6) @(posedge hclk);
		rdc(seq_pkg::A_PC, 32'h0);
		rdc(seq_pkg::A_PRE, 32'h0);
		repeat (8) @(posedge hclk);
		rdc(seq_pkg::A_PC, 32'h0);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge hclk);
		wr(seq_pkg::A_STAT, 32'h00);
		wr(seq_pkg::A_CMD, {16'h0, seq_pkg::OP_JUMP, 12'h123});
		repeat (20) @(posedge hclk);
		rdc(seq_pkg::A_PC, 32'h123);
		pin_edges(2);
		@(posedge hclk) wdt_timeout <= 1'b1;
		@(posedge hclk) wdt_timeout <= 1'b0;
		repeat (2) @(posedge hclk);
		rdc(seq_pkg::A_PRE, 32'h0);
		rdc(seq_pkg::A_PC, 32'h0);
		results();
	end
endmodule : program_counter_stack_and_core_regs_test
`default_nettype wire
